// ==== design/pft_consts.svh ====
// timing counts and reset values of the profile frame output timing block
`ifndef PFT_CONSTS_SVH
`define PFT_CONSTS_SVH

// all periods below are in pixel clock cycles
`define PFT_FS_LOW_CYC 36
`define PFT_COG_LEAD_CYC 10
`define PFT_COG_AT (`PFT_FS_LOW_CYC - `PFT_COG_LEAD_CYC)
// 23.5 cycles: armed 24 rises ahead, taken on the following falling edge
`define PFT_SET_LEAD_CYC 24
`define PFT_LS_LOW_CYC 60
`define PFT_PIX_ON_CYC 8
`define PFT_PIX_OFF_CYC 4
`define PFT_PIX_SLOT_CYC (`PFT_PIX_ON_CYC + `PFT_PIX_OFF_CYC)
`define PFT_WAIT_BASE 6
`define PFT_WAIT_MUL 12
`define PFT_WAIT_ADD 40
`define PFT_EXT_ROUND 6
`define PFT_EXT_STEP 12
// 84.5 cycles: whole part counted on rises, half cycle on the next falling edge
`define PFT_EXT_BASE 84
`define PFT_TRIG_TO_FS_CYC 48
`define PFT_TRIG_TO_FS_MIN 42
`define PFT_TRIG_TO_FS_MAX 54
`define PFT_WAIT_W 24
`define PFT_FRAME_T_W 16
`define PFT_BUF_DEPTH 2
`define PFT_BLANK_DATA 8'h00

`endif

// ==== design/pft_pkg.sv ====
// types shared by the profile frame output timing block
package pft_pkg;

  typedef enum logic [2:0] {
    ST_WAIT   = 3'b000,
    ST_FS_LOW = 3'b001,
    ST_X_GAP  = 3'b011,
    ST_X_DATA = 3'b010,
    ST_Y_GAP  = 3'b110,
    ST_Y_DATA = 3'b111
  } state_t;

  typedef struct packed {
    logic ext_mode;
    logic [7:0] window_width;
    logic [7:0] blanking;
  } settings_t;

  typedef struct packed {
    logic frame_sync;
    logic line_sync;
    logic [7:0] data;
  } video_t;

endpackage : pft_pkg

// ==== design/pixel_pair_buf.sv ====
// two-entry pixel buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
`include "pft_consts.svh"

module pixel_pair_buf (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [7:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [7:0] out_data_o
);

  logic [7:0] mem_q [`PFT_BUF_DEPTH];
  logic rd_q;
  logic wr_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != 2'(`PFT_BUF_DEPTH));
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
    end
  end

  property p_full_stalls;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (cnt_q == 2'(`PFT_BUF_DEPTH)) && !out_ready_i |=> !in_ready_o && out_valid_o;
  endproperty
  a_full_stalls: assert property (p_full_stalls) else $error("buffer took a word while full");

endmodule : pixel_pair_buf
`default_nettype wire

// ==== design/profile_frame_output_timing.sv ====
// frame, line and pixel output timing of the profile sensor
// Contract
// RULE1: settings take effect 23.5 cycles before frame_sync falls; frame_sync low 36 cycles.
// RULE2: centroid results refreshed 10 cycles before frame_sync rises.
// RULE3: integration ends under one cycle after frame_sync rises.
// RULE4: each pixel shown 8 cycles, blanked 4; line_sync low 60 cycles. A window_width of 0 keeps line_sync low 120 cycles through both gaps.
// RULE5: X projection group first, then Y group, with a gap between.
// RULE6: internal mode waits (6+window_width)*blanking*12+40 cycles before frame_sync falls.
// RULE7: external party drops start_trigger some freely chosen time after frame_sync rises.
// RULE8: external mode integration starts int((D+6)/12)*12+84.5 cycles after frame_sync rises.
// RULE9: external mode frame_sync falls 42 to 54 cycles after start_trigger rises.
// RULE10: 8-bit pixel_data with frame_sync, line_sync and pixel_clock outputs.
// RULE11: periods counted in pixel clocks; half cycles on the opposite edge.
// RULE12: settings latched only at the update point, constant within a frame.
`timescale 1ns/100ps
`default_nettype none
`include "pft_consts.svh"

module profile_frame_output_timing (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic pix_clk_in_i,
  input wire logic start_trigger_i,
  input wire pft_pkg::settings_t settings_i,
  input wire logic [15:0] cog_result_i,
  input wire logic pix_valid_i,
  output logic pix_ready_o,
  input wire logic [7:0] pix_data_i,
  output pft_pkg::video_t video_o,
  output logic pixel_clock_o,
  output logic [15:0] cog_result_o,
  output pft_pkg::settings_t settings_o,
  output logic integrating_o,
  output logic int_start_o,
  output logic int_end_o
);

  // ****************************************
  // pin synchronisers and edge detection
  // ****************************************
  logic [2:0] pclk_sync_q;
  logic [2:0] trig_sync_q;
  logic rise_ev;
  logic fall_ev;
  logic trig_rise;
  logic trig_fall;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pclk_sync_q <= 3'h0;
      trig_sync_q <= 3'h7;
    end else begin
      pclk_sync_q <= {pclk_sync_q[1:0], pix_clk_in_i};
      trig_sync_q <= {trig_sync_q[1:0], start_trigger_i};
    end
  end

  assign rise_ev = pclk_sync_q[1] && !pclk_sync_q[2];
  assign fall_ev = !pclk_sync_q[1] && pclk_sync_q[2];
  assign trig_rise = trig_sync_q[1] && !trig_sync_q[2];
  assign trig_fall = !trig_sync_q[1] && trig_sync_q[2];

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [`PFT_WAIT_W-1:0] wait_len(input pft_pkg::settings_t s);
    logic [`PFT_WAIT_W-1:0] w;
    w = `PFT_WAIT_W'(s.window_width) + `PFT_WAIT_W'(`PFT_WAIT_BASE);
    w = `PFT_WAIT_W'(w * `PFT_WAIT_W'(s.blanking));
    return `PFT_WAIT_W'(w * `PFT_WAIT_W'(`PFT_WAIT_MUL)) + `PFT_WAIT_W'(`PFT_WAIT_ADD);
  endfunction : wait_len

  function automatic logic [`PFT_FRAME_T_W-1:0] ext_start_at(input logic [`PFT_FRAME_T_W-1:0] d);
    logic [`PFT_FRAME_T_W-1:0] k;
    k = `PFT_FRAME_T_W'((d + `PFT_FRAME_T_W'(`PFT_EXT_ROUND)) / `PFT_FRAME_T_W'(`PFT_EXT_STEP));
    return `PFT_FRAME_T_W'(k * `PFT_FRAME_T_W'(`PFT_EXT_STEP)) + `PFT_FRAME_T_W'(`PFT_EXT_BASE);
  endfunction : ext_start_at

  // ****************************************
  // pixel buffer
  // ****************************************
  logic buf_valid;
  logic buf_ready;
  logic [7:0] buf_data;

  pixel_pair_buf u_buf (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(pix_valid_i),
    .in_ready_o(pix_ready_o),
    .in_data_i(pix_data_i),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_ready),
    .out_data_o(buf_data)
  );

  // ****************************************
  // frame sequencer
  // ****************************************
  pft_pkg::state_t state_q;
  pft_pkg::settings_t set_q;
  logic [`PFT_WAIT_W-1:0] rem_q;
  logic [7:0] cnt_q;
  logic [3:0] slot_q;
  logic [7:0] pix_q;
  logic trig_pend_q;
  logic set_arm_q;
  logic set_upd_q;
  logic cog_upd_q;
  logic data_st;
  logic last_pix;

  assign data_st = (state_q == pft_pkg::ST_X_DATA) || (state_q == pft_pkg::ST_Y_DATA);
  assign last_pix = (pix_q == set_q.window_width - 8'h01) && (slot_q == 4'(`PFT_PIX_SLOT_CYC - 1));
  // a pixel is taken at the start of its slot; an empty buffer shows blank data
  assign buf_ready = rise_ev && data_st && (slot_q == 4'h0);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_q <= pft_pkg::ST_WAIT;
      rem_q <= `PFT_WAIT_W'(`PFT_WAIT_ADD);
      cnt_q <= 8'h00;
      slot_q <= 4'h0;
      pix_q <= 8'h00;
      video_o <= '{frame_sync: 1'b1, line_sync: 1'b1, data: `PFT_BLANK_DATA};
    end else if (rise_ev) begin
      cnt_q <= cnt_q + 8'h01;
      case (state_q)
        pft_pkg::ST_WAIT: begin
          // RULE9 trigger sets delay
          if (set_q.ext_mode && trig_pend_q && rem_q == '0) begin
            rem_q <= `PFT_WAIT_W'(`PFT_TRIG_TO_FS_CYC);
          end else if (rem_q != '0) begin
            rem_q <= rem_q - `PFT_WAIT_W'(1);
          end
          // RULE1 frame sync falls
          if (rem_q == `PFT_WAIT_W'(1)) begin
            state_q <= pft_pkg::ST_FS_LOW;
            video_o.frame_sync <= 1'b0;
            cnt_q <= 8'h00;
          end
        end
        pft_pkg::ST_FS_LOW: begin
          // RULE1 low for 36
          if (cnt_q == 8'(`PFT_FS_LOW_CYC - 1)) begin
            video_o.frame_sync <= 1'b1;
            video_o.line_sync <= 1'b0;
            state_q <= pft_pkg::ST_X_GAP;
            cnt_q <= 8'h00;
          end
        end
        pft_pkg::ST_X_GAP, pft_pkg::ST_Y_GAP: begin
          // RULE4 line sync low 60
          if (cnt_q == 8'(`PFT_LS_LOW_CYC - 1)) begin
            video_o.line_sync <= 1'b1;
            slot_q <= 4'h0;
            pix_q <= 8'h00;
            // RULE5 X group before Y group
            if (set_q.window_width == 8'h00) begin
              state_q <= (state_q == pft_pkg::ST_X_GAP) ? pft_pkg::ST_Y_GAP : pft_pkg::ST_WAIT;
              video_o.line_sync <= (state_q != pft_pkg::ST_X_GAP);
              rem_q <= set_q.ext_mode ? '0 : wait_len(set_q);
              cnt_q <= 8'h00;
            end else begin
              state_q <= (state_q == pft_pkg::ST_X_GAP) ? pft_pkg::ST_X_DATA : pft_pkg::ST_Y_DATA;
            end
          end
        end
        pft_pkg::ST_X_DATA, pft_pkg::ST_Y_DATA: begin
          // RULE4 8 on, 4 blank
          if (slot_q == 4'h0) begin
            video_o.data <= buf_valid ? buf_data : `PFT_BLANK_DATA;
          end else if (slot_q == 4'(`PFT_PIX_ON_CYC)) begin
            video_o.data <= `PFT_BLANK_DATA;
          end
          slot_q <= (slot_q == 4'(`PFT_PIX_SLOT_CYC - 1)) ? 4'h0 : slot_q + 4'h1;
          if (slot_q == 4'(`PFT_PIX_SLOT_CYC - 1)) begin
            pix_q <= pix_q + 8'h01;
          end
          if (last_pix) begin
            cnt_q <= 8'h00;
            // RULE5 gap before Y group
            if (state_q == pft_pkg::ST_X_DATA) begin
              state_q <= pft_pkg::ST_Y_GAP;
              video_o.line_sync <= 1'b0;
            end else begin
              state_q <= pft_pkg::ST_WAIT;
              // RULE6 internal wait length
              rem_q <= set_q.ext_mode ? '0 : wait_len(set_q);
            end
          end
        end
        default: begin
          state_q <= pft_pkg::ST_WAIT;
        end
      endcase
    end
  end

  // RULE9 trigger rise remembered
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      trig_pend_q <= 1'b0;
    end else if (trig_rise) begin
      trig_pend_q <= 1'b1;
    end else if (rise_ev && state_q == pft_pkg::ST_WAIT && rem_q == '0 && set_q.ext_mode) begin
      trig_pend_q <= 1'b0;
    end
  end

  // ****************************************
  // settings and result update points
  // ****************************************
  // RULE12 latched once per frame
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      set_arm_q <= 1'b0;
      set_upd_q <= 1'b0;
      set_q <= '{ext_mode: 1'b0, window_width: 8'h00, blanking: 8'h00};
    end else begin
      set_upd_q <= 1'b0;
      if (rise_ev && state_q == pft_pkg::ST_WAIT && rem_q == `PFT_WAIT_W'(`PFT_SET_LEAD_CYC + 1)) begin
        set_arm_q <= 1'b1;
      end else if (fall_ev && set_arm_q) begin
        // RULE11 half cycle on falling edge
        set_arm_q <= 1'b0;
        set_upd_q <= 1'b1;
        set_q <= settings_i;
      end
    end
  end

  assign settings_o = set_q;

  // RULE2 results refreshed early
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cog_upd_q <= 1'b0;
      cog_result_o <= 16'h0000;
    end else begin
      cog_upd_q <= rise_ev && state_q == pft_pkg::ST_FS_LOW && cnt_q == 8'(`PFT_COG_AT - 1);
      if (rise_ev && state_q == pft_pkg::ST_FS_LOW && cnt_q == 8'(`PFT_COG_AT - 1)) begin
        cog_result_o <= cog_result_i;
      end
    end
  end

  // ****************************************
  // integration window
  // ****************************************
  logic fs_rise_seen_q;
  logic [`PFT_FRAME_T_W-1:0] t_q;
  logic [`PFT_FRAME_T_W-1:0] start_at_q;
  logic start_pend_q;
  logic start_half_q;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      fs_rise_seen_q <= 1'b0;
      t_q <= '0;
      start_at_q <= '0;
      start_pend_q <= 1'b0;
      start_half_q <= 1'b0;
      integrating_o <= 1'b1;
      int_start_o <= 1'b0;
      int_end_o <= 1'b0;
    end else begin
      int_start_o <= 1'b0;
      int_end_o <= 1'b0;
      if (rise_ev && state_q == pft_pkg::ST_FS_LOW && cnt_q == 8'(`PFT_FS_LOW_CYC - 1)) begin
        fs_rise_seen_q <= 1'b1;
        t_q <= '0;
        start_pend_q <= 1'b0;
      end else if (rise_ev && t_q != '1) begin
        t_q <= t_q + `PFT_FRAME_T_W'(1);
      end
      // RULE8 delay measured at trigger fall
      if (trig_fall && set_q.ext_mode) begin
        start_at_q <= ext_start_at(t_q);
        start_pend_q <= 1'b1;
      end
      // t_q reaches start_at_q on this rise; waiting for the compare a rise later starts one cycle late
      if (rise_ev && start_pend_q && t_q == start_at_q - `PFT_FRAME_T_W'(1)) begin
        start_pend_q <= 1'b0;
        start_half_q <= 1'b1;
      end
      if (fall_ev && fs_rise_seen_q) begin
        // RULE3 end on next falling edge
        fs_rise_seen_q <= 1'b0;
        integrating_o <= 1'b0;
        int_end_o <= 1'b1;
      end else if (fall_ev && !integrating_o && (start_half_q || !set_q.ext_mode)) begin
        // RULE8 half cycle on falling edge
        start_half_q <= 1'b0;
        integrating_o <= 1'b1;
        int_start_o <= 1'b1;
      end
    end
  end

  // RULE10 pixel clock echoed out
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pixel_clock_o <= 1'b0;
    end else begin
      pixel_clock_o <= pclk_sync_q[2];
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [7:0] h_fs_q;
  logic [7:0] h_ls_q;
  logic [7:0] h_trig_q;
  logic h_ext_wait_q;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      h_fs_q <= 8'h00;
      h_ls_q <= 8'h00;
      h_trig_q <= 8'h00;
      h_ext_wait_q <= 1'b0;
    end else begin
      // mode on entering the wait decides how the next fall is timed; a switch inside the wait comes too late
      if (state_q != pft_pkg::ST_WAIT) h_ext_wait_q <= set_q.ext_mode;
      if (video_o.frame_sync) h_fs_q <= 8'h00;
      else if (rise_ev) h_fs_q <= h_fs_q + 8'h01;
      if (video_o.line_sync) h_ls_q <= 8'h00;
      else if (rise_ev) h_ls_q <= h_ls_q + 8'h01;
      if (trig_rise) h_trig_q <= 8'h00;
      else if (rise_ev && h_trig_q != 8'hFF) h_trig_q <= h_trig_q + 8'h01;
    end
  end

  sequence s_fs_rise;
    $rose(video_o.frame_sync);
  endsequence
  sequence s_end_soon;
    ##[1:13] int_end_o;
  endsequence

  property p_fs_low;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(video_o.frame_sync) |-> h_fs_q == 8'd36;
  endproperty
  a_fs_low: assert property (p_fs_low) else $error("frame_sync low length wrong"); // RULE1
  property p_set_point;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    set_upd_q |-> state_q == pft_pkg::ST_WAIT && rem_q == `PFT_WAIT_W'(`PFT_SET_LEAD_CYC);
  endproperty
  a_set_point: assert property (p_set_point) else $error("settings taken at wrong point"); // RULE12
  property p_cog;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    cog_upd_q |-> !video_o.frame_sync && h_fs_q == 8'd26;
  endproperty
  a_cog: assert property (p_cog) else $error("result refresh not 10 before frame_sync rise"); // RULE2
  property p_int_end;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_fs_rise |-> s_end_soon;
  endproperty
  a_int_end: assert property (p_int_end) else $error("integration did not end after frame_sync"); // RULE3
  property p_ls_low;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(video_o.line_sync) |-> h_ls_q == 8'd60;
  endproperty
  a_ls_low: assert property (p_ls_low) else $error("line_sync low length wrong"); // RULE4
  property p_blank;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    data_st && slot_q > 4'd8 |-> video_o.data == `PFT_BLANK_DATA;
  endproperty
  a_blank: assert property (p_blank) else $error("pixel data not blanked"); // RULE4
  property p_order;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $changed(state_q) && state_q == pft_pkg::ST_Y_GAP |-> $past(state_q) != pft_pkg::ST_FS_LOW;
  endproperty
  a_order: assert property (p_order) else $error("Y group before X group"); // RULE5
  property p_trig_fs;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(video_o.frame_sync) && h_ext_wait_q |-> h_trig_q >= 8'd42 && h_trig_q <= 8'd54;
  endproperty
  a_trig_fs: assert property (p_trig_fs) else $error("frame_sync fall not 42..54 after trigger"); // RULE9

endmodule : profile_frame_output_timing
`default_nettype wire

// ==== verification/frame_grabber_model.sv ====
// capturing receiver and start trigger source at the far side of the video port
`timescale 1ns/100ps
`default_nettype none

module frame_grabber_model (
  input wire logic core_clk_i,
  input wire pft_pkg::video_t video_i,
  input wire logic pixel_clock_i,
  input wire logic [15:0] cog_i,
  input wire logic trig_en_i,
  input wire logic [15:0] trig_d_i,
  input wire logic [15:0] trig_hi_i,
  output logic start_trigger_o,
  output logic [31:0] trig_rise_at_o
);
  pft_pkg::video_t vq[$];
  logic [15:0] cq[$];
  logic pc_q = 1'b0;
  logic fs_q = 1'b1;
  logic trig_q = 1'b1;
  int fsr = 0;
  int rise_at = 0;

  assign start_trigger_o = trig_q;
  assign trig_rise_at_o = 32'(rise_at);

  // sample on the pixel falling edge, mid-period, where the outputs have long settled
  always @(posedge core_clk_i) begin
    pc_q <= pixel_clock_i;
    if (pc_q && !pixel_clock_i) begin
      vq.push_back(video_i);
      cq.push_back(cog_i);
      if (video_i.frame_sync && !fs_q) fsr = vq.size();
      fs_q = video_i.frame_sync;
      if (!trig_en_i) begin
        trig_q <= 1'b1;
      end else if (vq.size() == fsr + int'(trig_d_i)) begin
        trig_q <= 1'b0;
      end else if (vq.size() == fsr + int'(trig_hi_i)) begin
        trig_q <= 1'b1;
        rise_at = vq.size();
      end
    end
  end
endmodule : frame_grabber_model

`default_nettype wire

// ==== verification/profile_frame_output_timing_tb_top.sv ====
// self-checking bench for the profile frame output timing block
`timescale 1ns/100ps
`default_nettype none

module profile_frame_output_timing_tb_top;
  typedef struct {
    logic ext;
    logic [7:0] ww;
    logic [7:0] blank;
    logic [15:0] cog;
    int d;
    int exp;
  } row_t;
  // exp: internal wait (6+ww)*blank*12+40, or external start int((d+6)/12)*12+84
  // d values keep (d+6)%12 away from a step, so the trigger sync delay cannot move it
  row_t rows[5] = '{
    '{1'b0, 8'h01, 8'h01, 16'h1234, 0, 124},
    '{1'b0, 8'h02, 8'h00, 16'hBEEF, 0, 40},
    '{1'b1, 8'h01, 8'h00, 16'hA5A5, 3, 84},
    '{1'b1, 8'h01, 8'h01, 16'h5A5A, 20, 108},
    '{1'b1, 8'h01, 8'h02, 16'hC3C3, 40, 120}
  };
  row_t p = '{1'b0, 8'h00, 8'h00, 16'h0000, 0, 0};
  localparam int TIMEOUT = 90000;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic pix_clk = 1'b0;
  logic trig;
  pft_pkg::settings_t settings = '0;
  logic [15:0] cog_in = 16'h0000;
  logic pix_valid = 1'b0;
  logic pix_ready;
  logic [7:0] pix_data = 8'h00;
  pft_pkg::video_t video;
  logic pclk;
  logic [15:0] cog_out;
  pft_pkg::settings_t set_out;
  pft_pkg::settings_t set_q = '0;
  logic integ, int_start, int_end;
  logic trig_en = 1'b0;
  logic [15:0] trig_d = 16'h0000;
  logic [7:0] feed_q[$];
  logic fs_q = 1'b1;
  int cyc = 0, fsr_cyc = 0, fsf_cyc = 0, st_cyc = 0, end_cyc = 0, set_cyc = 0;
  int fail_count = 0;
  int checked = 0;

  initial forever #2 core_clk = ~core_clk;
  // link clock phase unrelated to the core clock
  initial begin
    #7.3;
    forever #24 pix_clk = ~pix_clk;
  end

  profile_frame_output_timing dut (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .pix_clk_in_i(pix_clk), .start_trigger_i(trig),
    .settings_i(settings), .cog_result_i(cog_in), .pix_valid_i(pix_valid), .pix_ready_o(pix_ready),
    .pix_data_i(pix_data), .video_o(video), .pixel_clock_o(pclk), .cog_result_o(cog_out),
    .settings_o(set_out), .integrating_o(integ), .int_start_o(int_start), .int_end_o(int_end)
  );

  frame_grabber_model grab (
    .core_clk_i(core_clk), .video_i(video), .pixel_clock_i(pclk), .cog_i(cog_out), .trig_en_i(trig_en),
    .trig_d_i(trig_d), .trig_hi_i(16'h012C), .start_trigger_o(trig), .trig_rise_at_o()
  );

  // ****************************************
  // event times and pixel feed
  // ****************************************
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    fs_q <= video.frame_sync;
    set_q <= set_out;
    if (fs_q === 1'b0 && video.frame_sync === 1'b1) fsr_cyc <= cyc;
    if (fs_q === 1'b1 && video.frame_sync === 1'b0) fsf_cyc <= cyc;
    if (set_out !== set_q) set_cyc <= cyc;
    if (int_start === 1'b1) st_cyc <= cyc;
    if (int_end === 1'b1) end_cyc <= cyc;
    if (cyc == TIMEOUT) begin
      fail_count++;
      test_done();
    end
  end

  // a word stays offered until the buffer takes it
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pix_valid <= 1'b0;
    end else begin
      if (pix_valid && pix_ready) void'(feed_q.pop_front());
      pix_valid <= feed_q.size() > 0;
      pix_data <= feed_q.size() > 0 ? feed_q[0] : 8'h00;
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%0h expected=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic wait_fs(input logic lvl);
    for (int n = 0; n < 30000 && video.frame_sync !== lvl; n++) @(posedge core_clk);
  endtask : wait_fs

  function automatic int find(int i, logic ls, logic lvl);
    while (i < grab.vq.size() && (ls ? grab.vq[i].line_sync : grab.vq[i].frame_sync) !== lvl) i++;
    return i;
  endfunction : find

  task automatic check_group(input int from, input int ww, input logic [7:0] base, output int last);
    int g;
    int h;
    g = find(from, 1'b1, 1'b0);
    h = find(g, 1'b1, 1'b1);
    check(h - g, 60);
    for (int i = 0; i < 12 * ww; i++) begin
      check(grab.vq[h + 1 + i].data, (i % 12 < 8) ? 8'(base + i / 12) : 8'h00);
    end
    last = h + 1 + 12 * (ww - 1);
  endtask : check_group

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int s0, f, r, lx, ly, f2;
    row_t w;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (rows[k]) begin
      w = rows[k];
      @(posedge core_clk);
      settings <= {w.ext, w.ww, w.blank};
      for (int j = 0; j < 4 * w.ww; j++) feed_q.push_back(8'(8'h10 * (k + 1) + j % (2 * w.ww)));
      repeat (20) @(posedge core_clk);
      check(set_out, {p.ext, p.ww, p.blank});
      if (k == 0) begin
        check(pix_ready, 1'b0);
        check(feed_q.size(), 2);
      end
      for (int n = 0; n < 30000 && set_out !== {w.ext, w.ww, w.blank}; n++) @(posedge core_clk);
      trig_en <= w.ext;
      trig_d <= 16'(w.d);
      s0 = grab.vq.size();
      wait_fs(1'b0);
      @(posedge core_clk);
      cog_in <= w.cog;
      check(fsf_cyc - set_cyc >= 281 && fsf_cyc - set_cyc <= 283, 1);
      wait_fs(1'b1);
      wait_fs(1'b0);
      // the grabber records the low frame_sync only half a pixel cycle after the fall
      repeat (12) @(posedge core_clk);
      f = find(s0, 1'b0, 1'b0);
      r = find(f, 1'b0, 1'b1);
      check(r - f, 36);
      check(grab.cq[r - 10], w.cog);
      check(grab.cq[r - 11], p.cog);
      check(end_cyc - fsr_cyc > 0 && end_cyc - fsr_cyc < 12, 1);
      check_group(r, w.ww, 8'(8'h10 * (k + 1)), lx);
      check_group(lx + 11, w.ww, 8'(8'h10 * (k + 1) + w.ww), ly);
      f2 = find(ly + 12, 1'b0, 1'b0);
      if (w.ext) begin
        check(f2 - int'(grab.trig_rise_at_o) inside {[42:54]}, 1);
        check(st_cyc - fsr_cyc inside {[w.exp * 12 + 5:w.exp * 12 + 7]}, 1);
      end else begin
        check(f2 - ly - 11 inside {[w.exp:w.exp + 1]}, 1);
      end
      p = w;
    end
    // second reset in mid-run, outputs back to idle levels
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    check({video, integ, int_start, int_end, cog_out, set_out, pclk},
          {10'h300, 3'h4, 16'h0000, 17'h00000, 1'h0});
    test_done();
  end
endmodule : profile_frame_output_timing_tb_top

`default_nettype wire
